// ===== dcra_pkg.sv
package dcra_pkg;
	localparam int NUM_DRIVES = 8;
	localparam int DRV_W = 3;
	localparam int GROUP_SIZE = 3;
	localparam int CLK_HZ = 100_000_000;
	localparam int STAGGER_S = 10;
	localparam longint STAGGER_CYC = longint'(STAGGER_S) * longint'(CLK_HZ);
	localparam logic [7:0] SENSE3_RESERVED_BIT = 8'h08;
	localparam logic [7:0] STAT_HOLDOFF = 8'h10;
	localparam logic [7:0] STAT_BUSY = 8'h10;
	localparam logic [7:0] STAT_OK = 8'h00;

	typedef struct packed {
		logic req;
		logic [2:0] drive;
		logic chain_end;
		logic intr_done;
		logic sense_done;
		logic start_chain;
		logic seek;
	} dcra_chan_req_t;

	typedef struct packed {
		logic grant;
		logic holdoff;
		logic busy;
		logic attn;
		logic [7:0] status;
		logic [7:0] third_sense_byte;
	} dcra_chan_rsp_t;
endpackage

// ===== dcra_owner_mem.sv
`timescale 1ns/1ps
`default_nettype none
// per-drive owner table; read data registered
module dcra_owner_mem #(
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic i_sys_clk, // clock
	input wire logic i_rst, // async reset
	input wire logic i_we, // write enable
	input wire logic [AW-1:0] i_waddr, // write index
	input wire logic [2:0] i_wdata, // {valid, remote, chan}
	input wire logic [AW-1:0] i_raddr, // read index
	output logic [2:0] o_rdata // registered read data
);
	logic [2:0] mem_ff [DEPTH];
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= 3'h0;
			end
			o_rdata <= 3'h0;
		end else begin
			if (i_we) begin
				mem_ff[i_waddr] <= i_wdata;
			end
			o_rdata <= (i_we && i_waddr == i_raddr) ? i_wdata : mem_ff[i_raddr];
		end
	end
endmodule // dcra_owner_mem
`default_nettype wire

// ===== dcra_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (RL1) free controller accepts either channel
// (RL2) first requester holds until chain/interrupt/sense done
// (RL3) held-off channel gets hold-off status byte
// (RL4) interrupt held-off channel when controller frees
// (RL5) drive reserved to first requesting channel
// (RL6) reserved idle drive: sense byte bit set
// (RL7) reserved drive with active chain: busy
// (RL8) chain end releases drive reservation
// (RL9) power drives in groups of three, staggered
// (RL10) one drive transfers, others may seek
// (RL11) one to eight drives, dedicated lines
// (RL12) simultaneous request: channel zero wins
module dcra_arbiter #(
	parameter int NDRV = dcra_pkg::NUM_DRIVES,
	parameter longint STAGGER = dcra_pkg::STAGGER_CYC
) (
	input wire logic i_sys_clk, // 100 MHz clock
	input wire logic i_rst, // async reset, high
	input wire dcra_pkg::dcra_chan_req_t i_ch0, // channel zero request group
	input wire dcra_pkg::dcra_chan_req_t i_ch1, // channel one request group
	input wire logic [NDRV-1:0] i_remote_rsv, // drive held by other controller (pin)
	input wire logic [NDRV-1:0] i_remote_chain, // other controller chain active (pin)
	input wire logic i_power_switch, // subsystem_power_switch (pin)
	output dcra_pkg::dcra_chan_rsp_t o_rsp0, // channel zero answer
	output dcra_pkg::dcra_chan_rsp_t o_rsp1, // channel one answer
	output logic [NDRV-1:0] o_local_rsv, // drive reserved by this controller
	output logic [NDRV-1:0] o_drive_power, // power_control_unit drive enables
	output logic [NDRV-1:0] o_xfer_sel, // one-hot data transfer select
	output logic [NDRV-1:0] o_seek_en // off-line seek enable
);
	import dcra_pkg::*;

	typedef enum logic [1:0] {ST_FREE, ST_OWN0, ST_OWN1} dcra_state_t;
	dcra_state_t state_ff, nxt_state;

	// pin synchronisers
	logic [NDRV-1:0] rrsv_s1_ff, rrsv_ff, rchn_s1_ff, rchn_ff;
	logic pwr_s1_ff, pwr_ff;
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			rrsv_s1_ff <= '0;
			rrsv_ff <= '0;
			rchn_s1_ff <= '0;
			rchn_ff <= '0;
			pwr_s1_ff <= 1'b0;
			pwr_ff <= 1'b0;
		end else begin
			rrsv_s1_ff <= i_remote_rsv;
			rrsv_ff <= rrsv_s1_ff;
			rchn_s1_ff <= i_remote_chain;
			rchn_ff <= rchn_s1_ff;
			pwr_s1_ff <= i_power_switch;
			pwr_ff <= pwr_s1_ff;
		end
	end

	// controller reservation
	logic chain_done_ff, intr_done_ff, sense_done_ff;
	logic pend0_ff, pend1_ff;
	logic [2:0] sel_drive_ff;
	wire own0 = (state_ff == ST_OWN0);
	wire own1 = (state_ff == ST_OWN1);
	wire cur_chain_end = own0 ? i_ch0.chain_end : i_ch1.chain_end;
	wire cur_intr = own0 ? i_ch0.intr_done : i_ch1.intr_done;
	wire cur_sense = own0 ? i_ch0.sense_done : i_ch1.sense_done;
	wire all_done = (chain_done_ff | cur_chain_end) & (intr_done_ff | cur_intr)
		& (sense_done_ff | cur_sense); // RL2
	wire grant0 = (state_ff == ST_FREE) && i_ch0.req; // RL1 RL12
	wire grant1 = (state_ff == ST_FREE) && i_ch1.req && !i_ch0.req; // RL1 RL12
	wire hold0 = i_ch0.req && (own1 || ((state_ff == ST_FREE) && 1'b0)); // RL3
	wire hold1 = i_ch1.req && (own0 || ((state_ff == ST_FREE) && i_ch0.req)); // RL3 RL12
	wire release_now = (own0 || own1) && all_done;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_FREE: begin
				if (grant0) begin
					nxt_state = ST_OWN0;
				end else if (grant1) begin
					nxt_state = ST_OWN1;
				end
			end
			ST_OWN0, ST_OWN1: begin
				if (release_now) begin
					nxt_state = ST_FREE; // RL2
				end
			end
			default: nxt_state = ST_FREE;
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= ST_FREE;
			chain_done_ff <= 1'b0;
			intr_done_ff <= 1'b0;
			sense_done_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			chain_done_ff <= release_now || grant0 || grant1 ? 1'b0 : (chain_done_ff | cur_chain_end);
			intr_done_ff <= release_now || grant0 || grant1 ? 1'b0 : (intr_done_ff | cur_intr);
			sense_done_ff <= release_now || grant0 || grant1 ? 1'b0 : (sense_done_ff | cur_sense);
		end
	end

	// pending hold-off flags; a new hold-off wins over the clearing interrupt pulse
	wire attn0 = pend0_ff && (state_ff == ST_FREE); // RL4
	wire attn1 = pend1_ff && (state_ff == ST_FREE); // RL4
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			pend0_ff <= 1'b0;
			pend1_ff <= 1'b0;
		end else begin
			pend0_ff <= hold0 | (pend0_ff & ~attn0); // RL4
			pend1_ff <= hold1 | (pend1_ff & ~attn1); // RL4
		end
	end

	// drive reservation: owner table plus fast valid vector
	logic [NDRV-1:0] rsv_ff, rsv_ch_ff, chain_act_ff;
	// the granting edge must already look at the new owner's drive
	wire [2:0] req_drv = (own1 || grant1) ? i_ch1.drive : i_ch0.drive;
	wire drv_req = grant0 | grant1 | ((own0 & i_ch0.req) | (own1 & i_ch1.req));
	wire req_ch = own1 | grant1;
	wire remote_held = rrsv_ff[req_drv]; // RL5
	wire local_other = rsv_ff[req_drv] && (rsv_ch_ff[req_drv] != req_ch); // RL5
	wire drv_conflict = drv_req && (remote_held || local_other);
	wire other_chain = remote_held ? rchn_ff[req_drv] : chain_act_ff[req_drv];
	wire drv_busy = drv_conflict && other_chain; // RL7
	wire drv_sense = drv_conflict && !other_chain; // RL6
	wire drv_take = drv_req && !drv_conflict;

	genvar g;
	generate
		for (g = 0; g < NDRV; g++) begin : g_drv
			wire hit = (req_drv == 3'(g));
			wire rel = rsv_ff[g] && (own0 || own1) && cur_chain_end
				&& (rsv_ch_ff[g] == own1); // RL8
			always_ff @(posedge i_sys_clk or posedge i_rst) begin
				if (i_rst) begin
					rsv_ff[g] <= 1'b0;
					rsv_ch_ff[g] <= 1'b0;
					chain_act_ff[g] <= 1'b0;
				end else if (drv_take && hit) begin
					rsv_ff[g] <= 1'b1; // RL5
					rsv_ch_ff[g] <= req_ch;
					chain_act_ff[g] <= chain_act_ff[g] | (own1 ? i_ch1.start_chain : i_ch0.start_chain);
				end else if (rel) begin
					rsv_ff[g] <= 1'b0; // RL8
					chain_act_ff[g] <= 1'b0;
				end
			end
		end
	endgenerate

	logic [2:0] owner_rd;
	dcra_owner_mem #(.DEPTH(NDRV), .AW(DRV_W)) u_owner (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_we(drv_take),
		.i_waddr(req_drv),
		.i_wdata({1'b1, 1'b0, req_ch}),
		.i_raddr(sel_drive_ff),
		.o_rdata(owner_rd)
	);

	// staggered power-up
	logic [63:0] stag_cnt_ff;
	logic [3:0] groups_on_ff;
	wire stag_tick = (stag_cnt_ff == 64'(STAGGER - 1));
	wire all_on = (int'(groups_on_ff) * GROUP_SIZE >= NDRV);
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			stag_cnt_ff <= 64'h0;
			groups_on_ff <= 4'h0;
		end else if (!pwr_ff) begin
			stag_cnt_ff <= 64'h0;
			groups_on_ff <= 4'h0;
		end else if (groups_on_ff == 4'h0) begin
			groups_on_ff <= 4'h1; // RL9 first group at once
		end else if (!all_on) begin
			stag_cnt_ff <= stag_tick ? 64'h0 : stag_cnt_ff + 64'h1;
			if (stag_tick) begin
				groups_on_ff <= groups_on_ff + 4'h1; // RL9
			end
		end
	end

	// outputs, all registered
	logic [NDRV-1:0] pwr_mask;
	always_comb begin
		for (int i = 0; i < NDRV; i++) begin
			pwr_mask[i] = (i / GROUP_SIZE) < int'(groups_on_ff); // RL9 RL11
		end
	end
	wire [7:0] stat0 = (hold0 || (own0 && drv_busy)) ? STAT_BUSY : STAT_OK;
	wire [7:0] stat1 = (hold1 || (own1 && drv_busy)) ? STAT_HOLDOFF : STAT_OK; // RL3 RL7
	wire [7:0] sense0 = (own0 || grant0) && drv_sense ? SENSE3_RESERVED_BIT : 8'h00; // RL6
	wire [7:0] sense1 = (own1 || grant1) && drv_sense ? SENSE3_RESERVED_BIT : 8'h00; // RL6
	wire xfer_ok = (own0 || own1) && owner_rd[2] && (owner_rd[0] == own1);

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rsp0 <= '0;
			o_rsp1 <= '0;
			o_local_rsv <= '0;
			o_drive_power <= '0;
			o_xfer_sel <= '0;
			o_seek_en <= '0;
			sel_drive_ff <= 3'h0;
		end else begin
			o_rsp0 <= '{grant: own0 | grant0, holdoff: hold0, busy: own0 & drv_busy,
				attn: attn0, status: stat0, third_sense_byte: sense0};
			o_rsp1 <= '{grant: own1 | grant1, holdoff: hold1, busy: own1 & drv_busy,
				attn: attn1, status: stat1, third_sense_byte: sense1};
			o_local_rsv <= rsv_ff;
			o_drive_power <= pwr_mask;
			if (drv_take) begin
				sel_drive_ff <= req_drv;
			end
			// one drive transfers; seeks free on the rest of the powered drives
			o_xfer_sel <= xfer_ok ? (NDRV'(1) << sel_drive_ff) : '0; // RL10
			o_seek_en <= pwr_mask & ~(xfer_ok ? (NDRV'(1) << sel_drive_ff) : '0); // RL10
		end
	end
endmodule // dcra_arbiter
`default_nettype wire

// ===== dcra_arbiter_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dcra_arbiter_props #(
	parameter int NDRV = dcra_pkg::NUM_DRIVES,
	parameter longint STAGGER = dcra_pkg::STAGGER_CYC
) (
	input wire logic i_sys_clk, // clock
	input wire logic i_rst, // reset
	input wire dcra_pkg::dcra_chan_req_t i_ch0, // host 0
	input wire dcra_pkg::dcra_chan_req_t i_ch1, // host 1
	input wire dcra_pkg::dcra_chan_rsp_t o_rsp0, // answer 0
	input wire dcra_pkg::dcra_chan_rsp_t o_rsp1, // answer 1
	input wire logic [NDRV-1:0] o_drive_power, // power
	input wire logic [NDRV-1:0] o_xfer_sel // transfer
);
	import dcra_pkg::*;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	wire logic free = !o_rsp0.grant && !o_rsp1.grant;
	wire logic done0 = i_ch0.chain_end || i_ch0.intr_done || i_ch0.sense_done;
	// grant output trails the release by one cycle, so skip the cycle after done
	sequence held0_s; o_rsp0.grant && !done0 && !$past(done0); endsequence
	sequence freed_s; $fell(o_rsp0.grant) && $past(o_rsp1.holdoff); endsequence
	first_wins_a: assert property (free && i_ch0.req |=> o_rsp0.grant && !o_rsp1.grant)
		else $error("channel zero not granted");
	free_accept_a: assert property (free && i_ch1.req && !i_ch0.req |=> o_rsp1.grant)
		else $error("channel one not granted");
	owner_holds_a: assert property (held0_s |=> o_rsp0.grant)
		else $error("reservation dropped early");
	single_owner_a: assert property (!(o_rsp0.grant && o_rsp1.grant))
		else $error("both channels granted");
	holdoff_status_a: assert property (held0_s ##0 i_ch1.req
		|=> o_rsp1.holdoff && o_rsp1.status == STAT_HOLDOFF)
		else $error("no hold-off status");
	attn_after_free_a: assert property (freed_s |-> ##[0:2] o_rsp1.attn)
		else $error("no interrupt to waiting channel");
	attn_pulse_a: assert property (o_rsp1.attn |=> !o_rsp1.attn)
		else $error("interrupt longer than a cycle");
	xfer_onehot_a: assert property ($onehot0(o_xfer_sel))
		else $error("several drives transferring");
	power_group_a: assert property
		($countones(o_drive_power & ~$past(o_drive_power)) <= GROUP_SIZE)
		else $error("too many drives powered at once");
endmodule // dcra_arbiter_props
bind dcra_arbiter dcra_arbiter_props #(.NDRV(NDRV), .STAGGER(STAGGER)) i_props (
	.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ch0(i_ch0), .i_ch1(i_ch1), .o_rsp0(o_rsp0),
	.o_rsp1(o_rsp1), .o_drive_power(o_drive_power), .o_xfer_sel(o_xfer_sel));
`default_nettype wire

// ===== dcra_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcra_host_model (
	input wire logic i_sys_clk, // clock
	input wire logic i_rst, // reset
	input wire logic i_go, // start job
	input wire logic [2:0] i_drive, // drive
	input wire logic [3:0] i_hold, // owned cycles
	input wire dcra_pkg::dcra_chan_rsp_t i_rsp, // answer
	output var dcra_pkg::dcra_chan_req_t o_req // request
);
	import dcra_pkg::*;
	logic [3:0] cnt_ff;
	// request held until the job ends, all done pulses together
	// acts on the rising edge so bench stimulus from the falling edge is settled
	always @(posedge i_sys_clk) begin
		o_req.start_chain <= 1'b0;
		{o_req.chain_end, o_req.intr_done, o_req.sense_done} <= 3'h0;
		if (i_rst) begin
			o_req <= '0;
			cnt_ff <= 4'h0;
		end else if (!o_req.req) begin
			o_req.req <= i_go;
			o_req.drive <= i_drive;
		end else if (i_rsp.grant) begin
			cnt_ff <= cnt_ff + 4'h1;
			o_req.start_chain <= (cnt_ff == 4'h0);
			if (cnt_ff == i_hold) begin
				{o_req.chain_end, o_req.intr_done, o_req.sense_done} <= 3'h7;
				o_req.req <= 1'b0;
				cnt_ff <= 4'h0;
			end
		end
	end
endmodule // dcra_host_model
`default_nettype wire

// ===== test_dcra_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module test_dcra_arbiter;
	import dcra_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic pwr = 1'b0;
	logic [7:0] rrsv = 8'h00;
	logic [7:0] rchn = 8'h00;
	logic [1:0] go = 2'h0;
	logic [1:0][2:0] drv = '0;
	logic [2:0] d;
	logic [1:0] g_q = 2'h0;
	logic [1:0] exp_q[$];
	int fails = 0;
	int cmp_count = 0;
	int seed = 32'h2bbf;
	dcra_chan_req_t q0, q1;
	dcra_chan_rsp_t r0, r1;
	logic [7:0] lrsv, dpwr, xfer, seek;
	wire logic [1:0] gr = {r1.grant, r0.grant};
	initial forever #5 clk = ~clk;
	dcra_arbiter #(.STAGGER(20)) i_dut (.i_sys_clk(clk), .i_rst(rst), .i_ch0(q0), .i_ch1(q1),
		.i_remote_rsv(rrsv), .i_remote_chain(rchn), .i_power_switch(pwr), .o_rsp0(r0),
		.o_rsp1(r1), .o_local_rsv(lrsv), .o_drive_power(dpwr), .o_xfer_sel(xfer),
		.o_seek_en(seek));
	dcra_host_model i_host0 (.i_sys_clk(clk), .i_rst(rst), .i_go(go[0]), .i_drive(drv[0]),
		.i_hold(4'h6), .i_rsp(r0), .o_req(q0));
	dcra_host_model i_host1 (.i_sys_clk(clk), .i_rst(rst), .i_go(go[1]), .i_drive(drv[1]),
		.i_hold(4'h6), .i_rsp(r1), .o_req(q1));
	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic pick(input int w);
		return w == 0 ? r0.grant : w == 1 ? r1.grant : w == 2 ? r1.attn : gr == 2'h0;
	endfunction
	task automatic wait_on(input int w);
		for (int i = 0; i < 200 && pick(w) !== 1'b1; i++) @(negedge clk);
		// a wait that runs out is a hang, never a pass
		if (pick(w) !== 1'b1) fails++;
	endtask
	task automatic job(input int ch, input logic [2:0] dr);
		exp_q.push_back(ch == 0 ? 2'h1 : 2'h2);
		drv[ch] = dr;
		go[ch] = 1'b1;
		wait_on(ch);
		go[ch] = 1'b0;
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(negedge clk) begin
		if (|(gr & ~g_q))
			check("grant", 9'(gr), 9'(exp_q.size() ? exp_q.pop_front() : 2'h0));
		g_q <= gr;
	end
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		report_and_stop();
	end
	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		pwr = 1'b1;
		d = 3'($random(seed));
		go[1] = 1'b1;
		drv[1] = d + 3'h1;
		job(0, d);
		exp_q.push_back(2'h2);
		repeat (2) @(negedge clk);
		check("holdoff", {r1.holdoff, r1.status}, {1'b1, STAT_HOLDOFF});
		check("drive held", 9'(lrsv[d]), 9'h1);
		check("xfer", 9'(xfer), 9'(8'h01 << d));
		wait_on(2);
		check("attn", 9'(r1.attn), 9'h1);
		wait_on(1);
		go[1] = 1'b0;
		check("drive freed", 9'(lrsv[d]), 9'h0);
		for (int k = 0; k < 2; k++) begin
			wait_on(3);
			d = 3'($random(seed));
			rrsv[d] = 1'b1;
			rchn[d] = k[0];
			// remote pins pass two sync flops first
			repeat (4) @(negedge clk);
			job(0, d);
			@(negedge clk);
			check("busy", 9'(r0.busy), 9'(k));
			if (k == 0)
				check("sense", 9'(r0.third_sense_byte & SENSE3_RESERVED_BIT), 9'h8);
			rrsv = 8'h00;
		end
		wait_on(3);
		check("power", 9'(dpwr), 9'h0ff);
		check("xfer idle", 9'(xfer), 9'h000);
		check("seek", 9'(seek), 9'h0ff);
		check("grants left", 9'(exp_q.size()), 9'h000);
		report_and_stop();
	end
endmodule // test_dcra_arbiter
`default_nettype wire
